// File: design/nv_prog_ctrl.sv
// Programming control for the OTP array and the EEPROM array.
// Assumes CPU memory writes arrive as one-cycle pulses on pclk and
// that mode, supply detectors and high-supply detect are async pins.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module nv_prog_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        special_mode_pin,
    input  wire logic        low_supply_pin,
    input  wire logic        program_supply_pin,
    input  wire logic        mem_wr,
    input  wire logic        otp_hit,
    input  wire logic [15:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output logic             otp_read_en,
    output logic [15:0]      otp_prog_addr,
    output logic [7:0]       otp_prog_data,
    output logic             otp_dual_byte,
    output logic             otp_extra_col,
    output logic             otp_extra_row,
    output logic             otp_voltage,
    output logic             nv_hit,
    output logic             nv_read_en,
    output logic [15:0]      nv_prog_addr,
    output logic [7:0]       nv_prog_data,
    output logic             nv_target_config,
    output logic             nv_erase,
    output logic [1:0]       nv_erase_scope,
    output logic             nv_voltage,
    output logic             pump_clock_sel
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end else begin
            pin_meta_reg <= {program_supply_pin, low_supply_pin,
                             special_mode_pin};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    wire special  = pin_sync_reg[0];
    wire low_supp = pin_sync_reg[1];
    wire vpp_high = pin_sync_reg[2];

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    function automatic logic [15:0] mask_addr(
        input logic [15:0] a, input logic dual,
        input logic col, input logic row);
        logic [15:0] m;
        m = a;
        if (dual) m[5] = 1'b0;
        if (col) m[4:0] = 5'h00;
        if (row) m[11:6] = 6'h00;
        return m;
    endfunction : mask_addr

    function automatic logic [4:0] region_of(input logic [11:0] o);
        if (o < nv_prog_pkg::REGION1_START) return 5'b00001;
        else if (o < nv_prog_pkg::REGION2_START) return 5'b00010;
        else if (o < nv_prog_pkg::REGION3_START) return 5'b00100;
        else if (o < nv_prog_pkg::REGION4_START) return 5'b01000;
        else return 5'b10000;
    endfunction : region_of

    wire        setup_ph = psel & ~penable;
    wire        access   = psel & penable;
    wire        wr_acc   = access & pwrite;
    wire [9:0]  word     = paddr[11:2];
    wire        sel_ep   = word == {2'b00, nv_prog_pkg::EPROM_CTRL_IDX};
    wire        sel_bp   = word == {2'b00, nv_prog_pkg::BLOCK_PROT_IDX};
    wire        sel_mp   = word == {2'b00, nv_prog_pkg::MAP_POS_IDX};
    wire        sel_po   = word == {2'b00, nv_prog_pkg::PUMP_OPT_IDX};
    wire        sel_ee   = word == {2'b00, nv_prog_pkg::EEPROM_CTRL_IDX};
    wire        mapped   = sel_ep | sel_bp | sel_mp | sel_po | sel_ee;
    wire [7:0]  wd       = pwdata[7:0];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  ep_reg, ep_next;
    logic [7:0]  ee_reg, ee_next;
    logic [7:0]  bp_reg, bp_next;
    logic [3:0]  map_reg;
    logic        map_done_reg;
    logic        pump_sel_reg;
    logic        low_supply_inhibit_reg;
    logic [6:0]  age_reg;
    logic        bp_done_reg;

    wire ep_vpp   = ep_reg[nv_prog_pkg::OTP_VOLT_BIT];
    wire ep_latch = ep_reg[nv_prog_pkg::OTP_LATCH_BIT];
    wire ee_latch = ee_reg[nv_prog_pkg::NV_LATCH_BIT];
    wire ee_pump  = ee_reg[nv_prog_pkg::NV_PUMP_BIT];
    wire ee_erase = ee_reg[nv_prog_pkg::ERASE_MODE_BIT];
    wire ee_byte  = ee_reg[nv_prog_pkg::ERASE_BYTE_BIT];
    wire ee_row   = ee_reg[nv_prog_pkg::ERASE_ROW_BIT];
    wire in_window = age_reg < nv_prog_pkg::GUARD_WINDOW_CYCLES;
    // Only one early clearing write outside special mode; later normal-mode writes can only add guards
    wire bp_clr_ok = special | (in_window & ~bp_done_reg);

    always_comb begin
        ep_next = ep_reg;
        if (special) begin
            ep_next[nv_prog_pkg::DUAL_BYTE_BIT] =
                wd[nv_prog_pkg::DUAL_BYTE_BIT];
            ep_next[nv_prog_pkg::EXTRA_COL_BIT] =
                wd[nv_prog_pkg::EXTRA_COL_BIT];
            ep_next[nv_prog_pkg::EXTRA_ROW_BIT] =
                wd[nv_prog_pkg::EXTRA_ROW_BIT];
        end
        if (!ep_vpp)
            ep_next[nv_prog_pkg::OTP_LATCH_BIT] =
                wd[nv_prog_pkg::OTP_LATCH_BIT] & vpp_high;
        if (ep_latch)
            ep_next[nv_prog_pkg::OTP_VOLT_BIT] =
                wd[nv_prog_pkg::OTP_VOLT_BIT];
    end

    always_comb begin
        ee_next = wd;
        ee_next[7:6] = 2'b00;
        ee_next[nv_prog_pkg::LOW_SUPPLY_BIT] = 1'b0;
        bp_next = bp_clr_ok ? wd : (bp_reg | wd);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ep_reg <= nv_prog_pkg::EPROM_CTRL_RST;
            ee_reg <= nv_prog_pkg::EEPROM_CTRL_RST;
            bp_reg <= nv_prog_pkg::BLOCK_PROT_RST;
            map_reg <= nv_prog_pkg::MAP_POS_RST;
            map_done_reg <= 1'b0;
            pump_sel_reg <= 1'b0;
        end else if (wr_acc) begin
            if (sel_ep) ep_reg <= ep_next;
            if (sel_ee) ee_reg <= ee_next;
            if (sel_bp) bp_reg <= bp_next;
            if (sel_mp && (special || !map_done_reg)) begin
                map_reg <= wd[7:4];
                map_done_reg <= 1'b1;
            end
            if (sel_po) pump_sel_reg <= wd[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_reg <= 7'd0;
            bp_done_reg <= 1'b0;
            low_supply_inhibit_reg <= 1'b0;
        end else begin
            if (in_window) age_reg <= age_reg + 7'd1;
            if (wr_acc && sel_bp && in_window) bp_done_reg <= 1'b1;
            low_supply_inhibit_reg <= bp_reg[nv_prog_pkg::SUPPLY_GUARD_BIT]
                        & low_supp;
        end
    end

    // ------------------------------------------------------------
    // Read path and answer
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (sel_ep) begin
            rd_byte = ep_reg & 8'hB9;
            if (!special) rd_byte = rd_byte & 8'h21;
        end else if (sel_ee) begin
            rd_byte = ee_reg;
            rd_byte[nv_prog_pkg::LOW_SUPPLY_BIT] = low_supply_inhibit_reg;
        end else if (sel_bp) rd_byte = bp_reg;
        else if (sel_mp) rd_byte = {map_reg, 4'h0};
        else if (sel_po) rd_byte = {7'h00, pump_sel_reg};
    end

    // Read data is taken in the setup cycle, so no wait state is needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0000_0000;
        else if (setup_ph && !pwrite) prdata <= {24'h00_0000, rd_byte};
    end

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // ------------------------------------------------------------
    // Array side
    // ------------------------------------------------------------
    wire [11:0] off      = mem_addr[11:0];
    wire        nv_range = (mem_addr[15:12] == map_reg)
                           && (off >= nv_prog_pkg::NV_BASE);
    wire        cfg_addr = off == nv_prog_pkg::CONFIG_OFFSET;
    // The EEPROM latch takes priority over the OTP latch
    wire        otp_cap  = ep_latch & ~ee_latch & mem_wr & otp_hit;
    wire        nv_cap   = ee_latch & mem_wr & (nv_range | cfg_addr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            otp_prog_addr <= 16'h0000;
            otp_prog_data <= 8'h00;
            nv_prog_addr <= 16'h0000;
            nv_prog_data <= nv_prog_pkg::ERASED_BYTE;
            nv_target_config <= 1'b0;
        end else begin
            if (otp_cap) begin
                otp_prog_addr <= mask_addr(mem_addr,
                    ep_reg[nv_prog_pkg::DUAL_BYTE_BIT],
                    ep_reg[nv_prog_pkg::EXTRA_COL_BIT],
                    ep_reg[nv_prog_pkg::EXTRA_ROW_BIT]);
                otp_prog_data <= mem_wdata;
            end
            if (nv_cap) begin
                nv_prog_addr <= mem_addr;
                nv_prog_data <= ee_erase ? nv_prog_pkg::ERASED_BYTE
                                         : mem_wdata;
                nv_target_config <= cfg_addr & ~nv_range;
            end
        end
    end

    nv_prog_pkg::erase_scope_t scope;
    assign scope = ee_byte ? nv_prog_pkg::ERASE_BYTE
                 : (ee_row ? nv_prog_pkg::ERASE_ROW
                           : nv_prog_pkg::ERASE_BULK);

    wire [4:0] region   = region_of(nv_prog_addr[11:0]);
    wire       blk_lock = |({bp_reg[nv_prog_pkg::UPPER_GUARD_BIT],
                             bp_reg[3:0]} & region);
    wire       bulk_ref = ee_erase & (scope != nv_prog_pkg::ERASE_BYTE)
                          & bp_reg[nv_prog_pkg::BULK_GUARD_BIT];
    wire       cfg_ref  = nv_target_config
                          & bp_reg[nv_prog_pkg::CONFIG_GUARD_BIT];
    wire       arr_ref  = ~nv_target_config & (bulk_ref
                          | (~ee_erase & blk_lock));
    wire       refused  = low_supply_inhibit_reg | cfg_ref | arr_ref;

    // Voltage stays on while the pump and latch bits are set and no guard or low-supply inhibit refuses it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) nv_voltage <= 1'b0;
        else nv_voltage <= ee_pump & ee_latch & ~refused;
    end

    assign otp_read_en    = ~ep_latch;
    assign otp_dual_byte  = ep_reg[nv_prog_pkg::DUAL_BYTE_BIT];
    assign otp_extra_col  = ep_reg[nv_prog_pkg::EXTRA_COL_BIT];
    assign otp_extra_row  = ep_reg[nv_prog_pkg::EXTRA_ROW_BIT];
    assign otp_voltage    = ep_vpp;
    assign nv_hit         = nv_range;
    assign nv_read_en     = ~ee_latch;
    assign nv_erase       = ee_erase;
    assign nv_erase_scope = scope;
    assign pump_clock_sel = pump_sel_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic rd_ep_normal_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rd_ep_normal_reg <= 1'b0;
        else rd_ep_normal_reg <= setup_ph & ~pwrite & sel_ep & ~special;
    end

    dual_read_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_ep_normal_reg |-> (prdata[7] == 1'b0 && prdata[4:3] == 2'b00))
        else $error("special-only bits visible in normal mode");

    latch_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && sel_ep && ep_vpp) |=> $stable(ep_latch))
        else $error("otp latch changed while voltage on");

    capture_addr_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        otp_cap |=> (otp_prog_data == $past(mem_wdata)
                     && otp_prog_addr[15:12] == $past(mem_addr[15:12])))
        else $error("otp capture lost address or data");

    dual_bit5_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (otp_cap && otp_dual_byte) |=> otp_prog_addr[5] == 1'b0)
        else $error("bit 5 kept in dual-byte mode");

    volt_gate_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && sel_ep && !ep_latch && !ep_vpp) |=> !otp_voltage)
        else $error("otp voltage set without latch");

    nv_unmapped_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ee_latch |-> !nv_read_en)
        else $error("eeprom readable while latched");

    bulk_refuse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (bulk_ref && !nv_target_config) |=> !nv_voltage)
        else $error("bulk or row erase under guard");

    guard_set_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && sel_bp) |=> ((bp_reg & $past(wd)) == $past(wd)))
        else $error("guard bit not set by write");

    low_supply_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !bp_reg[nv_prog_pkg::SUPPLY_GUARD_BIT] |=> !low_supply_inhibit_reg)
        else $error("low-supply flag set without guard");

    vpp_detect_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !vpp_high |=> !$rose(ep_latch))
        else $error("otp latch set without high supply");

    cfg_refuse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cfg_ref |=> !nv_voltage)
        else $error("config byte voltage under guard");

    block_refuse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (blk_lock && !ee_erase && !nv_target_config) |=> !nv_voltage)
        else $error("guarded region programmed");

    supply_refuse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        low_supply_inhibit_reg |=> !nv_voltage)
        else $error("voltage on under low supply");

    erase_data_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (nv_cap && ee_erase) |=> nv_prog_data == nv_prog_pkg::ERASED_BYTE)
        else $error("erase target data not all ones");

    pump_off_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !ee_pump |=> !nv_voltage)
        else $error("voltage on with pump bit clear");

    erase_run_c: cover property (
        @(posedge pclk) disable iff (!presetn) nv_voltage && nv_erase);
    program_run_c: cover property (
        @(posedge pclk) disable iff (!presetn) nv_voltage && !nv_erase);
    otp_run_c: cover property (
        @(posedge pclk) disable iff (!presetn) otp_voltage && otp_dual_byte);
    config_run_c: cover property (
        @(posedge pclk) disable iff (!presetn) nv_voltage & nv_target_config);

endmodule : nv_prog_ctrl

`default_nettype wire

// File: design/nv_prog_pkg.sv
// Constants for the EPROM and EEPROM programming control block.
// Assumes an APB master with 32-bit data and one word per register.

package nv_prog_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] EPROM_CTRL_IDX   = 8'h2B;
    localparam logic [7:0] BLOCK_PROT_IDX   = 8'h35;
    localparam logic [7:0] MAP_POS_IDX      = 8'h37;
    localparam logic [7:0] PUMP_OPT_IDX     = 8'h39;
    localparam logic [7:0] EEPROM_CTRL_IDX  = 8'h3B;

    // eprom_program_control fields
    localparam int DUAL_BYTE_BIT   = 7;
    localparam int OTP_LATCH_BIT   = 5;
    localparam int EXTRA_COL_BIT   = 4;
    localparam int EXTRA_ROW_BIT   = 3;
    localparam int OTP_VOLT_BIT    = 0;
    // eeprom_program_control fields
    localparam int LOW_SUPPLY_BIT  = 5;
    localparam int ERASE_BYTE_BIT  = 4;
    localparam int ERASE_ROW_BIT   = 3;
    localparam int ERASE_MODE_BIT  = 2;
    localparam int NV_LATCH_BIT    = 1;
    localparam int NV_PUMP_BIT     = 0;
    // eeprom_block_protection fields
    localparam int BULK_GUARD_BIT  = 7;
    localparam int SUPPLY_GUARD_BIT = 6;
    localparam int UPPER_GUARD_BIT = 5;
    localparam int CONFIG_GUARD_BIT = 4;

    localparam logic [7:0] EPROM_CTRL_RST  = 8'h00;
    localparam logic [7:0] EEPROM_CTRL_RST = 8'h00;
    localparam logic [7:0] BLOCK_PROT_RST  = 8'hFF;
    localparam logic [3:0] MAP_POS_RST     = 4'h0;
    localparam logic [7:0] ERASED_BYTE     = 8'hFF;

    // EEPROM window and region starts inside a 4K block
    localparam logic [11:0] NV_BASE        = 12'hD80;
    localparam logic [11:0] REGION1_START  = 12'hDA0;
    localparam logic [11:0] REGION2_START  = 12'hDE0;
    localparam logic [11:0] REGION3_START  = 12'hE60;
    localparam logic [11:0] REGION4_START  = 12'hF80;
    localparam logic [11:0] CONFIG_OFFSET  = 12'h03F;

    localparam logic [6:0] GUARD_WINDOW_CYCLES = 7'd64;

    typedef enum logic [1:0] {
        ERASE_BULK = 2'b00,
        ERASE_ROW  = 2'b01,
        ERASE_BYTE = 2'b10
    } erase_scope_t;

endpackage : nv_prog_pkg

// File: tb/nv_array_model.sv
// Behavioural OTP and EEPROM storage behind the programming controller.
// Assumes the EEPROM window sits in 4K block 0 and the config byte at 03F.
`timescale 1ns/1ns
`default_nettype none

module nv_array_model (
    input  wire logic        pclk,
    input  wire logic [15:0] otp_prog_addr,
    input  wire logic [7:0]  otp_prog_data,
    input  wire logic        otp_dual_byte,
    input  wire logic        otp_voltage,
    input  wire logic [15:0] nv_prog_addr,
    input  wire logic [7:0]  nv_prog_data,
    input  wire logic        nv_target_config,
    input  wire logic        nv_erase,
    input  wire logic [1:0]  nv_erase_scope,
    input  wire logic        nv_voltage
);
    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0]  otp_mem [logic [15:0]];
    logic [7:0]  nv_mem [0:639];
    logic [7:0]  cfg_byte;
    logic        otp_last;
    logic        nv_last;
    logic [11:0] off;

    assign off = nv_prog_addr[11:0] - nv_prog_pkg::NV_BASE;

    initial begin
        for (int i = 0; i < 640; i++) nv_mem[i] = 8'hFF;
        cfg_byte = 8'hFF;
        otp_last = 1'b0;
        nv_last  = 1'b0;
    end

    // ----------------------------------------
    // Cell update on rising voltage only
    // ----------------------------------------
    // Pulse length is not modelled; software owns the timing
    always @(posedge pclk) begin
        otp_last <= otp_voltage;
        nv_last  <= nv_voltage;
        if (otp_voltage && !otp_last) begin
            otp_mem[otp_prog_addr] = otp_prog_data;
            if (otp_dual_byte)
                otp_mem[otp_prog_addr ^ 16'h0020] = otp_prog_data;
        end
        if (nv_voltage && !nv_last) begin
            if (nv_target_config)
                cfg_byte = nv_erase ? 8'hFF : (cfg_byte & nv_prog_data);
            else if (!nv_erase)
                nv_mem[off] = nv_mem[off] & nv_prog_data;
            else
                for (int i = 0; i < 640; i++)
                    if (nv_erase_scope == 2'b00 || i == off ||
                        (nv_erase_scope == 2'b01 && i / 16 == off / 16))
                        nv_mem[i] = 8'hFF;
        end
    end
endmodule : nv_array_model

`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for nv_prog_ctrl with an APB master and array model.
// Assumes pready answers from the design and pins settle within 6 cycles.
`timescale 1ns/1ns
`default_nettype none

module testbench;
    typedef struct {
        logic [7:0] bp; logic [7:0] ctl; logic [15:0] addr;
        logic [1:0] scope; logic volt; logic [7:0] exp;
    } row_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        smode, lowsup, progsup, mem_wr, otp_hit;
    logic [15:0] mem_addr, otp_prog_addr, nv_prog_addr;
    logic [7:0]  mem_wdata, otp_prog_data, nv_prog_data, rd;
    logic        otp_read_en, otp_dual_byte, otp_extra_col, otp_extra_row;
    logic        otp_voltage, nv_hit, nv_read_en, nv_target_config, nv_erase;
    logic        nv_voltage, pump_clock_sel, er;
    logic [1:0]  nv_erase_scope;
    int          mismatches, comparisons, cycles;
    row_t rows [15] = '{
    '{8'h00,8'h02,16'h0D85,2'd0,1,8'h5A}, '{8'h00,8'h16,16'h0D85,2'd2,1,8'hFF},
    '{8'h00,8'h02,16'h0D85,2'd0,1,8'h5A}, '{8'h00,8'h0E,16'h0D8A,2'd1,1,8'hFF},
    '{8'h00,8'h02,16'h0D85,2'd0,1,8'h5A}, '{8'h80,8'h06,16'h0D85,2'd0,0,8'h5A},
    '{8'h80,8'h0E,16'h0D85,2'd1,0,8'h5A}, '{8'h00,8'h06,16'h0D85,2'd0,1,8'hFF},
    '{8'h00,8'h1E,16'h0D85,2'd2,1,8'hFF}, '{8'h01,8'h02,16'h0D85,2'd0,0,8'hFF},
    '{8'h01,8'h02,16'h0DA0,2'd0,1,8'h5A}, '{8'h20,8'h02,16'h0F80,2'd0,0,8'hFF},
    '{8'h10,8'h02,16'h003F,2'd0,0,8'hFF}, '{8'h00,8'h02,16'h003F,2'd0,1,8'h5A},
        '{8'h80,8'h16,16'h0DA0,2'd2,1,8'hFF}};

    nv_prog_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .special_mode_pin(smode), .low_supply_pin(lowsup),
        .program_supply_pin(progsup), .mem_wr(mem_wr), .otp_hit(otp_hit),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .otp_read_en(otp_read_en),
        .otp_prog_addr(otp_prog_addr), .otp_prog_data(otp_prog_data),
        .otp_dual_byte(otp_dual_byte), .otp_extra_col(otp_extra_col),
        .otp_extra_row(otp_extra_row), .otp_voltage(otp_voltage),
        .nv_hit(nv_hit), .nv_read_en(nv_read_en), .nv_prog_addr(nv_prog_addr),
        .nv_prog_data(nv_prog_data), .nv_target_config(nv_target_config),
        .nv_erase(nv_erase), .nv_erase_scope(nv_erase_scope),
        .nv_voltage(nv_voltage), .pump_clock_sel(pump_clock_sel));
    nv_array_model arr_u (.pclk(pclk), .otp_prog_addr(otp_prog_addr),
        .otp_prog_data(otp_prog_data), .otp_dual_byte(otp_dual_byte),
        .otp_voltage(otp_voltage), .nv_prog_addr(nv_prog_addr),
        .nv_prog_data(nv_prog_data), .nv_target_config(nv_target_config),
        .nv_erase(nv_erase), .nv_erase_scope(nv_erase_scope),
        .nv_voltage(nv_voltage));

    // ----------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Whole run needs about 460 cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= {2'b00, idx, 2'b00}; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, exp);
    endtask : rdchk
    task automatic mwr(input logic [15:0] a, input logic [7:0] d,
                       input logic h);
        @(posedge pclk);
        mem_wr <= 1'b1; otp_hit <= h; mem_addr <= a; mem_wdata <= d;
        @(posedge pclk);
        mem_wr <= 1'b0; otp_hit <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : mwr

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000;
        pwdata = 32'h0; smode = 0; lowsup = 0; progsup = 0; mem_wr = 0;
        otp_hit = 0; mem_addr = 16'h0000; mem_wdata = 8'h00; cycles = 0;
        mismatches = 0; comparisons = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(nv_prog_pkg::BLOCK_PROT_IDX, 8'hFF);
        rdchk(nv_prog_pkg::EPROM_CTRL_IDX, 8'h00);
        apb(1'b1, nv_prog_pkg::BLOCK_PROT_IDX, 8'h00);
        rdchk(nv_prog_pkg::BLOCK_PROT_IDX, 8'h00);
        apb(1'b1, nv_prog_pkg::BLOCK_PROT_IDX, 8'hFF);
        apb(1'b1, nv_prog_pkg::BLOCK_PROT_IDX, 8'h00);
        rdchk(nv_prog_pkg::BLOCK_PROT_IDX, 8'hFF);
        // Normal mode: test bits hidden, latch needs high supply
        apb(1'b1, nv_prog_pkg::EPROM_CTRL_IDX, 8'h98);
        rdchk(nv_prog_pkg::EPROM_CTRL_IDX, 8'h00);
        apb(1'b1, nv_prog_pkg::EPROM_CTRL_IDX, 8'h20);
        rdchk(nv_prog_pkg::EPROM_CTRL_IDX, 8'h00);
        progsup <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b1, nv_prog_pkg::EPROM_CTRL_IDX, 8'h01);
        rdchk(nv_prog_pkg::EPROM_CTRL_IDX, 8'h00);
        apb(1'b1, nv_prog_pkg::EPROM_CTRL_IDX, 8'h20);
        mwr(16'hA045, 8'h77, 1'b1);
        chk(otp_read_en, 1'b0);
        chk(otp_prog_data, 8'h77);
        apb(1'b1, nv_prog_pkg::EPROM_CTRL_IDX, 8'h00);
        smode <= 1'b1;
        repeat (4) @(posedge pclk);
        // EEPROM program and erase sequences over guard settings
        foreach (rows[i]) begin
            apb(1'b1, nv_prog_pkg::BLOCK_PROT_IDX, rows[i].bp);
            apb(1'b1, nv_prog_pkg::EEPROM_CTRL_IDX, rows[i].ctl);
            mwr(rows[i].addr, 8'h5A, 1'b0);
            chk(nv_read_en, 1'b0);
            chk(nv_prog_addr, rows[i].addr);
            chk(nv_target_config, rows[i].addr == 16'h003F);
            if (rows[i].ctl[2]) chk(nv_erase_scope, rows[i].scope);
            apb(1'b1, nv_prog_pkg::EEPROM_CTRL_IDX, rows[i].ctl | 8'h01);
            repeat (2) @(posedge pclk);
            chk(nv_voltage, rows[i].volt);
            apb(1'b1, nv_prog_pkg::EEPROM_CTRL_IDX, rows[i].ctl);
            apb(1'b1, nv_prog_pkg::EEPROM_CTRL_IDX, 8'h00);
            chk(rows[i].addr == 16'h003F ? arr_u.cfg_byte : arr_u.nv_mem[
                rows[i].addr[11:0] - nv_prog_pkg::NV_BASE], rows[i].exp);
        end
        // Special mode: dual byte, latch frozen while voltage on
        apb(1'b1, nv_prog_pkg::EPROM_CTRL_IDX, 8'hB8);
        rdchk(nv_prog_pkg::EPROM_CTRL_IDX, 8'hB8);
        chk({otp_dual_byte, otp_extra_col, otp_extra_row}, 3'b111);
        apb(1'b1, nv_prog_pkg::EPROM_CTRL_IDX, 8'hA0);
        mwr(16'hA065, 8'h33, 1'b1);
        apb(1'b1, nv_prog_pkg::EPROM_CTRL_IDX, 8'hA1);
        repeat (2) @(posedge pclk);
        chk(arr_u.otp_mem[16'hA065] & arr_u.otp_mem[16'hA045], 8'h33);
        apb(1'b1, nv_prog_pkg::EPROM_CTRL_IDX, 8'h00);
        rdchk(nv_prog_pkg::EPROM_CTRL_IDX, 8'h20);
        apb(1'b1, nv_prog_pkg::EPROM_CTRL_IDX, 8'h00);
        rdchk(nv_prog_pkg::EPROM_CTRL_IDX, 8'h00);
        // Low supply inhibit
        apb(1'b1, nv_prog_pkg::BLOCK_PROT_IDX, 8'h40);
        lowsup <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk(nv_prog_pkg::EEPROM_CTRL_IDX, 8'h20);
        apb(1'b1, nv_prog_pkg::EEPROM_CTRL_IDX, 8'h02);
        mwr(16'h0DA5, 8'h11, 1'b0);
        apb(1'b1, nv_prog_pkg::EEPROM_CTRL_IDX, 8'h03);
        repeat (2) @(posedge pclk);
        chk(nv_voltage, 1'b0);
        apb(1'b1, nv_prog_pkg::EEPROM_CTRL_IDX, 8'h00);
        apb(1'b1, nv_prog_pkg::BLOCK_PROT_IDX, 8'h00);
        repeat (6) @(posedge pclk);
        rdchk(nv_prog_pkg::EEPROM_CTRL_IDX, 8'h00);
        // Unmapped word, pump clock option, map position
        rdchk(8'h00, 8'h00);
        chk(er, 1'b1);
        apb(1'b1, nv_prog_pkg::PUMP_OPT_IDX, 8'h01);
        @(posedge pclk);
        chk(pump_clock_sel, 1'b1);
        apb(1'b1, nv_prog_pkg::MAP_POS_IDX, 8'h10);
        mem_addr <= 16'h1D85;
        @(posedge pclk);
        @(posedge pclk);
        chk(nv_hit, 1'b1);
        mem_addr <= 16'h0D85;
        @(posedge pclk);
        @(posedge pclk);
        chk(nv_hit, 1'b0);
        // Reset in mid-run restores guards and map position
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rdchk(nv_prog_pkg::BLOCK_PROT_IDX, 8'hFF);
        chk(nv_hit, 1'b1);
        complete_run();
    end
endmodule : testbench

`default_nettype wire
